// ### capture_channel.sv
// Purpose: Input capture channel with APB registers and interrupt
// Assumes: Idle, sleep and timer counts come from logic on i_clk
// Notes: Capture pin is synchronised before use
//
// Functional notes
// R1: Idle-stop set halts capture while the processor idles; clear keeps it running.
// R2: Time base select picks peripheral count or one of five timer counts.
// R3: Captures-per-interrupt raises the interrupt every first to fourth capture.
// R4: Captures-per-interrupt is ignored in every-edge and wake-up modes.
// R5: Read-only overflow flag sets when the buffer overflows.
// R6: Read-only buffer-not-empty flag shows unread captures remain.
// R7: Wake-up mode only flags rising edges during sleep or idle.
// R8: Unused mode performs no captures.
// R9: Off mode switches the channel off.
// R10: Every sixteenth rising edge is captured in prescale-16 mode.
// R11: Every fourth rising edge is captured in prescale-4 mode.
// R12: Each rising edge is captured in rising mode.
// R13: Each falling edge is captured in falling mode.
// R14: Every rising and falling edge is captured in every-edge mode.
// R15: Unimplemented control bits read zero and ignore writes.
// R16: Each capture stores the selected time base count, read in arrival order.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module capture_channel #(
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Capture pin and processor state
   input wire logic i_capture_channel,
   input wire logic i_cpu_idle,
   input wire logic i_cpu_sleep,
   // Time bases
   input wire capture_pkg::timebase_t i_timebase,
   // Interrupt
   output logic o_irq
);
   capture_pkg::ctrl_t ctrl_q;
   logic [2:0] stat_q;
   logic [2:0] stat_d;
   logic [2:0] mask_q;
   logic [15:0] periph_cnt_q;
   logic [3:0] pre_q;
   logic [1:0] cpi_cnt_q;
   logic ovf_q;
   logic rise;
   logic fall;
   logic fire;
   logic halted;
   logic wake_ev;
   logic capt_ev;
   logic [15:0] tb_val;
   logic [15:0] head;
   logic empty;
   logic full;
   logic acc;
   logic wr;
   logic rd;
   logic pop;
   logic flush;
   logic [15:0] ctrl_rd;
   capture_pkg::mode_t mode;
   logic [1:0] cpi_limit;

   assign mode = capture_pkg::mode_t'(ctrl_q.capture_mode_select);
   // Answer is built on the first access edge; writes and pops act at the completing edge
   assign acc = i_psel & i_penable & ~o_pready;
   assign wr = i_psel & i_penable & o_pready & i_pwrite;
   assign rd = i_psel & i_penable & o_pready & ~i_pwrite;
   assign pop = rd & (i_paddr == capture_pkg::BUF_OFS);
   assign flush = (mode == capture_pkg::MODE_OFF);

   // Pin synchroniser and edge detector
   capture_edge_sync u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_capture_channel),
      .o_rise(rise),
      .o_fall(fall)
   );

   // Capture buffer
   capture_fifo #(
      .WIDTH(16),
      .DEPTH(DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_flush(flush),
      .i_push(fire),
      .i_wdata(tb_val),
      .i_pop(pop),
      .o_rdata(head),
      .o_empty(empty),
      .o_full(full)
   );

   // Free-running peripheral clock count
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) periph_cnt_q <= '0;
      else periph_cnt_q <= periph_cnt_q + 16'h0001;
   end

   // Time base selection; reserved codes capture zero
   always_comb begin
      case (ctrl_q.capture_timebase_select)
         capture_pkg::TB_PERIPH: tb_val = periph_cnt_q; // R2
         capture_pkg::TB_TIMER_THREE: tb_val = i_timebase.timer_three_clock; // R2
         capture_pkg::TB_TIMER_TWO: tb_val = i_timebase.timer_two_clock;
         capture_pkg::TB_TIMER_FOUR: tb_val = i_timebase.timer_four_clock;
         capture_pkg::TB_TIMER_FIVE: tb_val = i_timebase.timer_five_clock;
         capture_pkg::TB_TIMER_ONE: tb_val = i_timebase.timer_one_clock;
         default: tb_val = 16'h0000;
      endcase
   end

   // Idle stop gate
   assign halted = ctrl_q.capture_idle_stop & i_cpu_idle; // R1

   // Capture event decode per mode
   always_comb begin
      fire = 1'b0;
      case (mode)
         capture_pkg::MODE_EDGE: fire = rise | fall; // R14
         capture_pkg::MODE_FALL: fire = fall; // R13
         capture_pkg::MODE_RISE: fire = rise; // R12
         capture_pkg::MODE_PRE4: fire = rise & (pre_q == capture_pkg::PRE4_LAST); // R11
         capture_pkg::MODE_PRE16: fire = rise & (pre_q == capture_pkg::PRE16_LAST); // R10
         capture_pkg::MODE_UNUSED: fire = 1'b0; // R8
         capture_pkg::MODE_WAKE: fire = 1'b0; // R7
         capture_pkg::MODE_OFF: fire = 1'b0; // R9
         default: fire = 1'b0;
      endcase
      if (halted) fire = 1'b0; // R1
   end

   // Prescaler of rising edges; restarts when mode is rewritten
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pre_q <= '0;
      end else if (wr && i_paddr == capture_pkg::CTRL_OFS) begin
         pre_q <= '0;
      end else if (rise && !halted) begin
         if (fire) pre_q <= '0; // R10 R11
         else pre_q <= pre_q + 4'h1;
      end
   end

   // Captures per interrupt, ignored in every-edge and wake-up modes
   assign cpi_limit = (mode == capture_pkg::MODE_EDGE || mode == capture_pkg::MODE_WAKE) ?
      2'b00 : ctrl_q.captures_per_interrupt; // R4
   assign capt_ev = fire & (cpi_cnt_q >= cpi_limit);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || flush) cpi_cnt_q <= '0;
      else if (capt_ev) cpi_cnt_q <= '0; // R3
      else if (fire) cpi_cnt_q <= cpi_cnt_q + 2'b01; // R3
   end

   // Wake-up event on rising edges during sleep or idle
   assign wake_ev = (mode == capture_pkg::MODE_WAKE) & rise & (i_cpu_sleep | i_cpu_idle); // R7

   // Overflow flag; set on push into a full buffer, cleared by switching off
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || flush) ovf_q <= 1'b0;
      else if (fire && full) ovf_q <= 1'b1; // R5
   end

   // Control register; only implemented bits are stored
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl_q <= '0;
      end else if (wr && i_paddr == capture_pkg::CTRL_OFS) begin
         ctrl_q.capture_idle_stop <= i_pwdata[capture_pkg::IDLE_STOP_POS];
         ctrl_q.capture_timebase_select <= i_pwdata[capture_pkg::TSEL_LSB +: 3];
         ctrl_q.captures_per_interrupt <= i_pwdata[capture_pkg::CPI_LSB +: 2];
         ctrl_q.capture_mode_select <= i_pwdata[capture_pkg::MODE_LSB +: 3];
      end
   end

   // Control read image; flags are read-only, gaps read zero
   always_comb begin
      ctrl_rd = capture_pkg::CTRL_RST;
      ctrl_rd[capture_pkg::IDLE_STOP_POS] = ctrl_q.capture_idle_stop;
      ctrl_rd[capture_pkg::TSEL_LSB +: 3] = ctrl_q.capture_timebase_select;
      ctrl_rd[capture_pkg::CPI_LSB +: 2] = ctrl_q.captures_per_interrupt;
      ctrl_rd[capture_pkg::OVF_POS] = ovf_q; // R5
      ctrl_rd[capture_pkg::BNE_POS] = ~empty; // R6
      ctrl_rd[capture_pkg::MODE_LSB +: 3] = ctrl_q.capture_mode_select;
      ctrl_rd = ctrl_rd & (capture_pkg::CTRL_WMASK | 16'h0018); // R15
   end

   // Sticky status; a set in the clearing cycle wins
   always_comb begin
      stat_d = stat_q;
      if (wr && i_paddr == capture_pkg::STAT_OFS) stat_d = stat_q & ~i_pwdata[2:0];
      stat_d[capture_pkg::ST_CAPT] = stat_d[capture_pkg::ST_CAPT] | capt_ev; // R3
      stat_d[capture_pkg::ST_WAKE] = stat_d[capture_pkg::ST_WAKE] | wake_ev;
      stat_d[capture_pkg::ST_OVF] = stat_d[capture_pkg::ST_OVF] | (fire & full);
   end

   // Status, mask and interrupt output
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         stat_q <= capture_pkg::STAT_RST;
         mask_q <= capture_pkg::MASK_RST;
         o_irq <= 1'b0;
      end else begin
         stat_q <= stat_d;
         if (wr && i_paddr == capture_pkg::MASK_OFS) mask_q <= i_pwdata[2:0];
         o_irq <= |(stat_d & mask_q);
      end
   end

   // APB answer one cycle into the access phase
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= acc;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
         if (acc) begin
            case (i_paddr)
               capture_pkg::CTRL_OFS: o_prdata <= {16'h0000, ctrl_rd};
               capture_pkg::BUF_OFS: o_prdata <= {16'h0000, empty ? 16'h0000 : head}; // R16
               capture_pkg::STAT_OFS: o_prdata <= {29'h0, stat_q};
               capture_pkg::MASK_OFS: o_prdata <= {29'h0, mask_q};
               default: o_pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Checks
   unimpl_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
      (ctrl_rd & 16'hC380) == 16'h0000) else $error("Unimplemented bits not zero");
   bne_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
      ctrl_rd[capture_pkg::BNE_POS] == !empty) else $error("Not-empty flag wrong");
   ovf_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
      fire && full && !flush |=> ovf_q) else $error("Overflow not flagged");
   off_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
      mode inside {capture_pkg::MODE_OFF, capture_pkg::MODE_UNUSED} |-> !fire)
      else $error("Capture while disabled");
   wake_nocap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
      mode == capture_pkg::MODE_WAKE && rise && i_cpu_sleep |-> !fire && wake_ev)
      else $error("Wake mode misbehaves");
   idle_halt_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R1
      ctrl_q.capture_idle_stop && i_cpu_idle |-> !fire) else $error("Capture during idle stop");
   edge_both_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
      mode == capture_pkg::MODE_EDGE && !halted && (rise || fall) |-> fire && capt_ev)
      else $error("Edge mode missed an edge");
   rise_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
      mode == capture_pkg::MODE_RISE && !halted |-> fire == rise) else $error("Rise mode wrong");
   fall_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
      mode == capture_pkg::MODE_FALL && !halted |-> fire == fall) else $error("Fall mode wrong");
   pre_four_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
      mode == capture_pkg::MODE_PRE4 && fire |-> pre_q == 4'h3) else $error("Prescale 4 wrong");
   irq_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R3
      capt_ev && mask_q[capture_pkg::ST_CAPT] |=> o_irq) else $error("Interrupt not raised");
endmodule
`default_nettype wire

// ### capture_pkg.sv
// Purpose: Shared constants and types of the input capture channel
// Assumes: 32-bit APB register access, 16-bit time bases
// Notes: Offsets are byte addresses of aligned words
package capture_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BUF_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] MASK_OFS = 8'h0C;
   // Control register field positions
   localparam int IDLE_STOP_POS = 13;
   localparam int TSEL_LSB = 10;
   localparam int CPI_LSB = 5;
   localparam int OVF_POS = 4;
   localparam int BNE_POS = 3;
   localparam int MODE_LSB = 0;
   // Writable control bits; the others read zero apart from the two read-only flag bits
   localparam logic [15:0] CTRL_WMASK = 16'h3C67;
   // Values after reset
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [2:0] STAT_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;
   // Status bit positions
   localparam int ST_CAPT = 0;
   localparam int ST_WAKE = 1;
   localparam int ST_OVF = 2;
   // Prescaled edge counts
   localparam logic [3:0] PRE4_LAST = 4'h3;
   localparam logic [3:0] PRE16_LAST = 4'hF;

   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_EDGE = 3'b001,
      MODE_FALL = 3'b010,
      MODE_RISE = 3'b011,
      MODE_PRE4 = 3'b100,
      MODE_PRE16 = 3'b101,
      MODE_UNUSED = 3'b110,
      MODE_WAKE = 3'b111
   } mode_t;

   typedef enum logic [2:0] {
      TB_TIMER_THREE = 3'b000,
      TB_TIMER_TWO = 3'b001,
      TB_TIMER_FOUR = 3'b010,
      TB_TIMER_FIVE = 3'b011,
      TB_TIMER_ONE = 3'b100,
      TB_PERIPH = 3'b111
   } tbase_t;

   // Stored control fields
   typedef struct packed {
      logic capture_idle_stop;
      logic [2:0] capture_timebase_select;
      logic [1:0] captures_per_interrupt;
      logic [2:0] capture_mode_select;
   } ctrl_t;

   // Time base counts from the timers
   typedef struct packed {
      logic [15:0] timer_one_clock;
      logic [15:0] timer_two_clock;
      logic [15:0] timer_three_clock;
      logic [15:0] timer_four_clock;
      logic [15:0] timer_five_clock;
   } timebase_t;
endpackage

// ### capture_edge_sync.sv
// Purpose: Synchronise the capture pin and flag its edges
// Assumes: Pin is asynchronous to i_clk
// Notes: Edge pulses last one cycle
`timescale 1ns/1ns
`default_nettype none
module capture_edge_sync (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Pin
   input wire logic i_pin,
   // Edge pulses
   output logic o_rise,
   output logic o_fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= i_pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge detection on the synchronised level
   assign o_rise = sync_q & ~prev_q;
   assign o_fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

// ### capture_fifo.sv
// Purpose: Small capture buffer memory with registered head word
// Assumes: Push and pop never both act on an empty buffer
// Notes: Push while full is refused and reported by o_full
`timescale 1ns/1ns
`default_nettype none
module capture_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Control
   input wire logic i_flush,
   input wire logic i_push,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic i_pop,
   // State
   output logic [WIDTH-1:0] o_rdata,
   output logic o_empty,
   output logic o_full
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic do_push;
   logic do_pop;

   assign do_push = i_push & ~o_full;
   assign do_pop = i_pop & ~o_empty;
   assign o_empty = (cnt_q == '0);
   assign o_full = (cnt_q == (AW+1)'(DEPTH));

   // Pointers and fill count
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || i_flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (do_pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // Storage and registered head word
   always_ff @(posedge i_clk) begin
      if (do_push) mem_q[wr_q] <= i_wdata;
      o_rdata <= mem_q[rd_q];
   end
endmodule
`default_nettype wire

// ### capture_timer_model.sv
// Purpose: Timer time base counts that feed the capture channel
// Assumes: Counts advance on i_clk only while i_run is high
// Notes: Distinct steps so a wrong time base select shows at once
`timescale 1ns/1ns
`default_nettype none
module capture_timer_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Control
   input wire logic i_run,
   // Time bases
   output capture_pkg::timebase_t o_timebase
);
   // Five counters with different steps, frozen while the bench captures
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_timebase <= {16'h1100, 16'h2200, 16'h3300, 16'h4400, 16'h5500};
      end else if (i_run) begin
         o_timebase.timer_one_clock <= o_timebase.timer_one_clock + 16'h0001;
         o_timebase.timer_two_clock <= o_timebase.timer_two_clock + 16'h0003;
         o_timebase.timer_three_clock <= o_timebase.timer_three_clock + 16'h0005;
         o_timebase.timer_four_clock <= o_timebase.timer_four_clock + 16'h0007;
         o_timebase.timer_five_clock <= o_timebase.timer_five_clock + 16'h0009;
      end
   end
endmodule
`default_nettype wire

// ### capture_channel_tb.sv
// Purpose: Self-checking bench of the capture channel over APB
// Assumes: One wait state per APB transfer, captures land within 6 cycles
// Notes: Expected read results queue up and are checked when pready shows
`timescale 1ns/1ns
`default_nettype none
module capture_channel_tb;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_t;
   logic clk, rst_n, psel, penable, pwrite, pin, idle, sleep, run;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, irq;
   capture_pkg::timebase_t tbase;
   note_t q[$];
   note_t nt;
   int error_cnt = 0;
   int checks = 0;
   int md[7] = '{3, 2, 1, 4, 5, 6, 0};
   int np[7] = '{3, 3, 2, 8, 16, 3, 2};
   int nc[7] = '{3, 3, 4, 2, 1, 0, 0};
   int ns[7] = '{0, 0, 1, 0, 0, 0, 0};
   capture_channel u_capture_channel (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_capture_channel(pin),
      .i_cpu_idle(idle), .i_cpu_sleep(sleep), .i_timebase(tbase), .o_irq(irq));
   capture_timer_model u_capture_timer_model (.i_clk(clk), .i_rst_n(rst_n), .i_run(run),
      .o_timebase(tbase));
   // Clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic stop_test();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (e !== g) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp1(input string n, input logic e, input logic g);
      checks++;
      if (e !== g) begin
         error_cnt++;
         $display("unexpected %s expected %b seen %b", n, e, g);
      end
   endtask
   // APB transfer; the expected answer is queued before the request starts
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic [31:0] m, input logic er);
      int n;
      q.push_back({e, m, er});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (n >= 20) begin
         error_cnt++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0, e, m, 1'b0);
   endtask
   // Fresh configuration: off first to flush, then run timers a random while
   task automatic cfg(input logic [31:0] c);
      wr(capture_pkg::CTRL_OFS, 32'h0);
      wr(capture_pkg::CTRL_OFS, c);
      wr(capture_pkg::STAT_OFS, 32'h7);
      run <= 1'b1;
      repeat ($urandom_range(3, 20)) @(posedge clk);
      run <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         pin <= 1'b1;
         repeat ($urandom_range(4, 6)) @(posedge clk);
         pin <= 1'b0;
         repeat ($urandom_range(4, 6)) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask
   function automatic logic [31:0] tval(input int t);
      case (t)
         0: tval = {16'h0, tbase.timer_three_clock};
         1: tval = {16'h0, tbase.timer_two_clock};
         2: tval = {16'h0, tbase.timer_four_clock};
         3: tval = {16'h0, tbase.timer_five_clock};
         4: tval = {16'h0, tbase.timer_one_clock};
         default: tval = 32'h0;
      endcase
   endfunction
   // Answer checker: oldest note against each pready pulse
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (q.size() == 0) begin
            cmp1("queue", 1'b0, 1'b1);
         end else begin
            nt = q.pop_front();
            cmp32("prdata", nt.d & nt.m, prdata & nt.m);
            cmp1("pslverr", nt.e, pslverr);
         end
      end
   end
   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, pin, idle, sleep, run} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(37));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(capture_pkg::CTRL_OFS, 32'h0, 32'hFFFFFFFF);
      rd(capture_pkg::STAT_OFS, 32'h0, 32'hFFFFFFFF);
      rd(capture_pkg::MASK_OFS, 32'h0, 32'hFFFFFFFF);
      apb(1'b0, 8'h10, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
      wr(capture_pkg::CTRL_OFS, 32'hFFFFFFFF);
      rd(capture_pkg::CTRL_OFS, 32'h3C67, 32'hFFFFFFFF);
      for (int t = 0; t < 8; t++) begin
         cfg((t << 10) | 3);
         pulse(1);
         rd(capture_pkg::BUF_OFS, tval(t), (t == 7) ? 32'h0 : 32'hFFFFFFFF);
         rd(capture_pkg::CTRL_OFS, (t << 10) | 3, 32'hFFFFFFFF);
      end
      for (int i = 0; i < 7; i++) begin
         cfg(32'h60 | md[i]);
         pulse(np[i]);
         for (int k = 0; k < nc[i]; k++) rd(capture_pkg::BUF_OFS, tval(0), 32'hFFFF);
         rd(capture_pkg::STAT_OFS, ns[i], 32'h1);
         rd(capture_pkg::CTRL_OFS, 32'h60 | md[i], 32'h1F);
      end
      wr(capture_pkg::MASK_OFS, 32'h1);
      for (int c = 0; c < 4; c++) begin
         cfg((c << 5) | 3);
         pulse(c);
         rd(capture_pkg::STAT_OFS, 32'h0, 32'h1);
         cmp1("irq", 1'b0, irq);
         pulse(1);
         rd(capture_pkg::STAT_OFS, 32'h1, 32'h1);
         cmp1("irq", 1'b1, irq);
      end
      cfg(32'h3);
      pulse(5);
      rd(capture_pkg::CTRL_OFS, 32'h1B, 32'hFFFF);
      wr(capture_pkg::CTRL_OFS, 32'h3);
      rd(capture_pkg::CTRL_OFS, 32'h1B, 32'hFFFF);
      rd(capture_pkg::STAT_OFS, 32'h4, 32'h4);
      repeat (4) rd(capture_pkg::BUF_OFS, tval(0), 32'hFFFF);
      wr(capture_pkg::MASK_OFS, 32'h4);
      repeat (2) @(posedge clk);
      cmp1("irq", 1'b1, irq);
      wr(capture_pkg::STAT_OFS, 32'h4);
      repeat (2) @(posedge clk);
      cmp1("irq", 1'b0, irq);
      cfg(32'h2003);
      idle <= 1'b1;
      pulse(1);
      rd(capture_pkg::CTRL_OFS, 32'h2003, 32'hFFFF);
      idle <= 1'b0;
      pulse(1);
      rd(capture_pkg::BUF_OFS, tval(0), 32'hFFFF);
      cfg(32'h3);
      idle <= 1'b1;
      pulse(1);
      rd(capture_pkg::BUF_OFS, tval(0), 32'hFFFF);
      idle <= 1'b0;
      cfg(32'h7);
      wr(capture_pkg::MASK_OFS, 32'h2);
      pulse(1);
      rd(capture_pkg::STAT_OFS, 32'h0, 32'h2);
      sleep <= 1'b1;
      pulse(1);
      rd(capture_pkg::STAT_OFS, 32'h2, 32'h2);
      rd(capture_pkg::CTRL_OFS, 32'h7, 32'hFFFF);
      cmp1("irq", 1'b1, irq);
      sleep <= 1'b0;
      wr(capture_pkg::STAT_OFS, 32'h2);
      repeat (2) @(posedge clk);
      cmp1("irq", 1'b0, irq);
      repeat (2) @(posedge clk);
      stop_test();
   end
endmodule
`default_nettype wire
